// >>> core/ausrw_rx.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Sixteen samples per bit, one shift per bit
// - Async only with port enabled, sync clear
// - Nine data bits when ninth-bit enable set
// - Frames accepted only while continuous receive set
// - Frame end sets flag; irq needs enable
// - Ninth bit and errors in status register
// - Low eight data bits in receive buffer
// - Clearing continuous receive clears latched errors
// - Address-detect enable bit for multidrop use
// - Address detect off: every frame stored, flagged
// - Priority bit; service needs enable and global
// - Sleep stops baud generator and reception
// - Wake-on-break is baud control bit one
// - Wake enabled: reception idle, line watched
// - Falling line edge is the wake event
// - Wake event sets the receive-done flag
// - Reading receive buffer clears pending flag
// - Rising edge after wake clears wake enable
// - Start, eight or nine data, stop bit
// - Least significant bit first, same baud
module ausrw_rx
    import ausrw_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output logic      [7:0]        rd_data_out,
    // Line and power state
    input  wire logic              serial_in_pin_in,
    input  wire logic              sleep_in,
    // Requests to the processor
    output logic                   irq_high_out,
    output logic                   irq_low_out,
    output logic                   wake_out
);

    //--------------------------------------------------------
    // State and helpers
    //--------------------------------------------------------
    ausrw_state_t q;
    ausrw_state_t d;
    logic         rx;
    logic         fall;
    logic         rise;
    logic         async_md;
    logic         run;
    logic         tick;
    logic         frame_end;
    logic         keep;
    logic         pend;
    logic [15:0]  reload;
    logic [3:0]   last_bit;
    logic [7:0]   rbyte;

    //--------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------
    always_comb
    begin
        d = q;
        rx = serial_in_pin_in;
        fall = q.rx_prev & ~rx;
        rise = ~q.rx_prev & rx;
        async_md = q.port_en & ~q.sync_mode;
        run = async_md & q.continuous_receive_enable & ~q.wake_on_break_enable & ~sleep_in & ~q.overrun_error_flag;
        reload = q.wide_divisor_select ? {q.div_hi, q.div_lo} : {8'h00, q.div_lo};
        tick = (q.brg_cnt == 16'h0000) & (q.high_speed_baud_select | (q.pre == PRE_LAST));
        last_bit = q.rx9 ? BITS9_LAST : BITS8_LAST;
        rbyte = q.rx9 ? q.shf[7:0] : q.shf[8:1];
        keep = ~(q.address_detect_enable & q.rx9 & ~q.shf[8]);
        frame_end = 1'b0;
        d.rx_prev = rx;
        d.rd_data = REG_RESET;

        // Baud generator, frozen while asleep or reception is off
        if (!run)
        begin
            d.brg_cnt = reload;
            d.pre = 2'h0;
        end
        else if (q.brg_cnt == 16'h0000)
        begin
            d.brg_cnt = reload;
            d.pre = q.pre + 2'h1;
        end
        else
            d.brg_cnt = q.brg_cnt - 16'h0001;

        // Register reads, answered one cycle later
        if (rd_en_in)
        begin
            case (addr_in)
                OFS_RX_STATUS_CTL:
                begin
                    d.rd_data[RS_PORT_EN_BIT] = q.port_en;
                    d.rd_data[RS_RX9_BIT] = q.rx9;
                    d.rd_data[RS_SREN_BIT] = q.sren;
                    d.rd_data[RS_CONTINUOUS_RECEIVE_ENABLE_BIT] = q.continuous_receive_enable;
                    d.rd_data[RS_ADDRESS_DETECT_ENABLE_BIT] = q.address_detect_enable;
                    d.rd_data[RS_FRAMING_ERROR_FLAG_BIT] = q.framing_error_flag;
                    d.rd_data[RS_OVERRUN_ERROR_FLAG_BIT] = q.overrun_error_flag;
                    d.rd_data[RS_RECEIVED_NINTH_BIT_BIT] = q.received_ninth_bit;
                end
                OFS_RX_BUFFER:
                begin
                    d.rd_data = q.rxbuf;
                    d.done = 1'b0;
                end
                OFS_TX_STATUS_CTL:
                begin
                    d.rd_data[TS_SYNC_BIT] = q.sync_mode;
                    d.rd_data[TS_HIGH_SPEED_BAUD_SELECT_BIT] = q.high_speed_baud_select;
                    d.rd_data[TS_TRMT_BIT] = 1'b1;
                end
                OFS_BAUD_CTL:
                begin
                    d.rd_data[BC_IDLE_BIT] = (q.st == ST_IDLE);
                    d.rd_data[BC_WIDE_DIVISOR_SELECT_BIT] = q.wide_divisor_select;
                    d.rd_data[BC_WUE_BIT] = q.wake_on_break_enable;
                end
                OFS_DIV_HIGH: d.rd_data = q.div_hi;
                OFS_DIV_LOW:  d.rd_data = q.div_lo;
                OFS_IRQ_CTL:
                begin
                    d.rd_data[IC_EN_BIT] = q.irq_en;
                    d.rd_data[IC_PRI_BIT] = q.irq_pri;
                    d.rd_data[IC_GIE_BIT] = q.global_irq_enable;
                    d.rd_data[IC_PERIPHERAL_IRQ_ENABLE_BIT] = q.peripheral_irq_enable;
                    d.rd_data[IC_DONE_BIT] = q.done;
                end
                default: d.rd_data = REG_RESET;
            endcase
        end

        // Register writes
        if (wr_en_in)
        begin
            case (addr_in)
                OFS_RX_STATUS_CTL:
                begin
                    d.port_en = wr_data_in[RS_PORT_EN_BIT];
                    d.rx9 = wr_data_in[RS_RX9_BIT];
                    d.sren = wr_data_in[RS_SREN_BIT];
                    d.continuous_receive_enable = wr_data_in[RS_CONTINUOUS_RECEIVE_ENABLE_BIT];
                    d.address_detect_enable = wr_data_in[RS_ADDRESS_DETECT_ENABLE_BIT];
                    if (!wr_data_in[RS_CONTINUOUS_RECEIVE_ENABLE_BIT])
                    begin
                        d.framing_error_flag = 1'b0;
                        d.overrun_error_flag = 1'b0;
                    end
                end
                OFS_TX_STATUS_CTL:
                begin
                    d.sync_mode = wr_data_in[TS_SYNC_BIT];
                    d.high_speed_baud_select = wr_data_in[TS_HIGH_SPEED_BAUD_SELECT_BIT];
                end
                OFS_BAUD_CTL:
                begin
                    d.wide_divisor_select = wr_data_in[BC_WIDE_DIVISOR_SELECT_BIT];
                    d.wake_on_break_enable = wr_data_in[BC_WUE_BIT];
                end
                OFS_DIV_HIGH: d.div_hi = wr_data_in;
                OFS_DIV_LOW:  d.div_lo = wr_data_in;
                OFS_IRQ_CTL:
                begin
                    d.irq_en = wr_data_in[IC_EN_BIT];
                    d.irq_pri = wr_data_in[IC_PRI_BIT];
                    d.global_irq_enable = wr_data_in[IC_GIE_BIT];
                    d.peripheral_irq_enable = wr_data_in[IC_PERIPHERAL_IRQ_ENABLE_BIT];
                end
                default: ;
            endcase
        end

        // Frame receiver, sampling at sixteen ticks per bit
        case (q.st)
            ST_IDLE:
            begin
                if (run && fall)
                begin
                    d.st = ST_START;
                    d.smp = 4'h0;
                end
            end
            ST_START:
            begin
                if (tick)
                begin
                    d.smp = q.smp + 4'h1;
                    if (q.smp == SMP_MID)
                    begin
                        d.smp = 4'h0;
                        d.bitn = 4'h0;
                        d.st = rx ? ST_IDLE : ST_DATA;
                    end
                end
            end
            ST_DATA:
            begin
                if (tick)
                begin
                    d.smp = q.smp + 4'h1;
                    if (q.smp == SMP_LAST)
                    begin
                        d.shf = {rx, q.shf[8:1]};
                        d.bitn = q.bitn + 4'h1;
                        if (q.bitn == last_bit)
                            d.st = ST_STOP;
                    end
                end
            end
            ST_STOP:
            begin
                if (tick)
                begin
                    d.smp = q.smp + 4'h1;
                    if (q.smp == SMP_LAST)
                    begin
                        frame_end = 1'b1;
                        d.st = ST_IDLE;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // Abort any frame when reception is not allowed
        if (!run)
            d.st = ST_IDLE;

        // Frame completion; set wins over a same-cycle read
        if (frame_end && keep)
        begin
            if (d.done)
                d.overrun_error_flag = 1'b1;
            else
            begin
                d.rxbuf = rbyte;
                d.received_ninth_bit = q.rx9 & q.shf[8];
                d.framing_error_flag = ~rx;
                d.done = 1'b1;
            end
        end

        // Wake-on-break detector
        if (q.wake_on_break_enable && async_md)
        begin
            if (fall && !q.wake_seen)
            begin
                d.done = 1'b1;
                d.wake_seen = 1'b1;
            end
            else if (rise && q.wake_seen)
            begin
                d.wake_on_break_enable = 1'b0;
                d.wake_seen = 1'b0;
            end
        end
        if (!d.wake_on_break_enable)
            d.wake_seen = 1'b0;
    end

    //--------------------------------------------------------
    // State register
    //--------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
            q.rx_prev <= 1'b1;                 // Line idles high: no false edge
        end
        else
        begin
            q <= d;
        end
    end

    //--------------------------------------------------------
    // Outputs
    //--------------------------------------------------------
    // Interrupt routing by priority level
    assign pend = q.done & q.irq_en & q.global_irq_enable;
    assign irq_high_out = pend & q.irq_pri;
    assign irq_low_out = pend & ~q.irq_pri & q.peripheral_irq_enable;
    assign wake_out = q.done & q.irq_en & sleep_in;
    assign rd_data_out = q.rd_data;

    //--------------------------------------------------------
    // Assertions
    //--------------------------------------------------------
    property p_sleep_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        sleep_in |=> (q.st == ST_IDLE);
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("frame in progress during sleep");

    property p_sync_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (q.sync_mode || !q.port_en || !q.continuous_receive_enable) |=> (q.st == ST_IDLE);
    endproperty
    a_sync_idle: assert property (p_sync_idle)
        else $error("receiver active outside async mode");

    property p_wue_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        q.wake_on_break_enable |=> (q.st == ST_IDLE) || !$past(q.wake_on_break_enable);
    endproperty
    a_wue_idle: assert property (p_wue_idle)
        else $error("frame reception while wake enabled");

    property p_no_irq_disabled;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!q.irq_en || !q.global_irq_enable) |-> !irq_high_out && !irq_low_out;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled)
        else $error("interrupt raised while disabled");

    property p_read_clears;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == OFS_RX_BUFFER && !frame_end && !q.wake_on_break_enable)
            |=> !q.done;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("buffer read left flag set");

    property p_rd_data;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_en_in && addr_in == OFS_RX_BUFFER) |=> (rd_data_out == $past(q.rxbuf));
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("wrong buffer read data");

    property p_continuous_receive_enable_clears;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_en_in && addr_in == OFS_RX_STATUS_CTL && !wr_data_in[RS_CONTINUOUS_RECEIVE_ENABLE_BIT] && !frame_end)
            |=> !q.overrun_error_flag && !q.framing_error_flag;
    endproperty
    a_continuous_receive_enable_clears: assert property (p_continuous_receive_enable_clears)
        else $error("errors not cleared by receive disable");

    property p_wake_flag;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (q.wake_on_break_enable && async_md && fall && !q.wake_seen) |=> q.done ##1 q.wake_seen || !q.wake_on_break_enable;
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake event did not set flag");

    property p_wue_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (q.wake_seen && q.wake_on_break_enable && async_md && rise) |=> !q.wake_on_break_enable;
    endproperty
    a_wue_clear: assert property (p_wue_clear)
        else $error("wake enable not cleared on rising edge");

    property p_overrun;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_end && keep && q.done && !(rd_en_in && addr_in == OFS_RX_BUFFER))
            |=> q.overrun_error_flag && (q.rxbuf == $past(q.rxbuf));
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or buffer overwritten");

    property p_discard;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (frame_end && !keep && !q.done && !q.wake_on_break_enable) |=> !q.done;
    endproperty
    a_discard: assert property (p_discard)
        else $error("non-address frame flagged");

    // Main scenarios
    c_frame: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        frame_end && keep && !q.done);
    c_wake: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        q.wake_seen && rise);
    c_overrun: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        !q.overrun_error_flag ##1 q.overrun_error_flag);
    c_ninth: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        frame_end && q.rx9 && q.address_detect_enable && keep);

endmodule

`default_nettype wire

// >>> core/ausrw_pkg.sv
//------------------------------------------------------------
// Shared constants and types of the serial receiver
//------------------------------------------------------------
package ausrw_pkg;

    // Register port width
    localparam int ADDR_W = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_RX_STATUS_CTL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_RX_BUFFER     = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_TX_STATUS_CTL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_BAUD_CTL      = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_DIV_HIGH      = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_DIV_LOW       = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTL       = 3'h6;

    // Receive status and control fields
    localparam int RS_PORT_EN_BIT = 7;
    localparam int RS_RX9_BIT     = 6;
    localparam int RS_SREN_BIT    = 5;
    localparam int RS_CONTINUOUS_RECEIVE_ENABLE_BIT    = 4;
    localparam int RS_ADDRESS_DETECT_ENABLE_BIT   = 3;
    localparam int RS_FRAMING_ERROR_FLAG_BIT    = 2;
    localparam int RS_OVERRUN_ERROR_FLAG_BIT    = 1;
    localparam int RS_RECEIVED_NINTH_BIT_BIT    = 0;

    // Transmit status and control fields
    localparam int TS_SYNC_BIT = 4;
    localparam int TS_HIGH_SPEED_BAUD_SELECT_BIT = 2;
    localparam int TS_TRMT_BIT = 1;

    // Baud control fields
    localparam int BC_IDLE_BIT  = 6;
    localparam int BC_WIDE_DIVISOR_SELECT_BIT = 3;
    localparam int BC_WUE_BIT   = 1;

    // Interrupt control fields
    localparam int IC_EN_BIT   = 0;
    localparam int IC_PRI_BIT  = 1;
    localparam int IC_GIE_BIT  = 2;
    localparam int IC_PERIPHERAL_IRQ_ENABLE_BIT = 3;
    localparam int IC_DONE_BIT = 4;

    // Read data of unset bits, unread cycles and unmapped places
    localparam logic [7:0] REG_RESET = 8'h00;

    // Sampling timing: sixteen samples per bit
    localparam int         SAMPLES_PER_BIT = 16;
    localparam logic [3:0] SMP_MID  = 4'(SAMPLES_PER_BIT / 2 - 1);
    localparam logic [3:0] SMP_LAST = 4'(SAMPLES_PER_BIT - 1);
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [3:0] BITS8_LAST = 4'h7;
    localparam logic [3:0] BITS9_LAST = 4'h8;

    // Receiver states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } ausrw_st_t;

    // Whole state of the receiver
    typedef struct packed {
        logic        port_en;
        logic        rx9;
        logic        sren;
        logic        continuous_receive_enable;
        logic        address_detect_enable;
        logic        framing_error_flag;
        logic        overrun_error_flag;
        logic        received_ninth_bit;
        logic [7:0]  rxbuf;
        logic        sync_mode;
        logic        high_speed_baud_select;
        logic        wide_divisor_select;
        logic        wake_on_break_enable;
        logic [7:0]  div_hi;
        logic [7:0]  div_lo;
        logic        irq_en;
        logic        irq_pri;
        logic        global_irq_enable;
        logic        peripheral_irq_enable;
        logic        done;
        logic [15:0] brg_cnt;
        logic [1:0]  pre;
        ausrw_st_t   st;
        logic [3:0]  smp;
        logic [3:0]  bitn;
        logic [8:0]  shf;
        logic        rx_prev;
        logic        wake_seen;
        logic [7:0]  rd_data;
    } ausrw_state_t;

endpackage

// >>> dv/ausrw_remote_tx.sv
`timescale 1ns/10ps
`default_nettype none

// -----------------------------
// Remote serial transmitter
// -----------------------------
module ausrw_remote_tx
(
    // Clock
    input  wire logic mclk_in,
    // Receive line
    output logic      line_out
);
    // Clocks per bit, changed by the bench
    int bit_clks = 16;

    // Line idles high between frames
    initial line_out = 1'b1;

    // Hold one level for whole bits
    task automatic hold(input logic lvl, input int nb);
        line_out <= lvl;
        repeat (nb * bit_clks) @(posedge mclk_in);
    endtask

    // Start, data lsb first, stop
    task automatic send(input logic [8:0] d, input int nd, input logic stp);
        hold(1'b0, 1);
        for (int i = 0; i < nd; i++)
            hold(d[i], 1);
        hold(stp, 1);
        if (!stp)
            hold(1'b1, 1);
    endtask

    // All-zero wake break, then a long idle gap
    task automatic wake_break();
        hold(1'b0, 13);
        hold(1'b1, 2);
    endtask
endmodule

`default_nettype wire

// >>> dv/ausrw_rx_test.sv
`timescale 1ns/10ps
`default_nettype none

// -----------------------------
// Receiver bench
// -----------------------------
module ausrw_rx_test
    import ausrw_pkg::*;
;
    logic              mclk_in  = 1'b0;
    logic              rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr     = '0;
    logic [7:0]        wdat     = 8'h00;
    logic              we       = 1'b0;
    logic              re       = 1'b0;
    logic              sleep    = 1'b0;
    logic [7:0]        rdat;
    logic [7:0]        v;
    logic              line;
    logic              irq_h;
    logic              irq_l;
    logic              wake;
    int                n_errors    = 0;
    int                check_count = 0;

    // Clock of 100 ns
    always #50 mclk_in = ~mclk_in;

    // Design and far side
    ausrw_rx dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdat),
        .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .serial_in_pin_in(line),
        .sleep_in(sleep), .irq_high_out(irq_h), .irq_low_out(irq_l), .wake_out(wake)
    );
    ausrw_remote_tx remote (.mclk_in(mclk_in), .line_out(line));

    // Verdict and end of run
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdat <= d;
        we   <= 1'b1;
        @(posedge mclk_in);
        we   <= 1'b0;
    endtask

    // Read; data stands in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        re   <= 1'b1;
        @(posedge mclk_in);
        re   <= 1'b0;
        @(negedge mclk_in);
        d = rdat;
    endtask

    // Read and compare
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask

    // Bounded wait on high irq, low irq or wake
    task automatic wait_for(input int which);
        int   k;
        logic s;
        for (k = 0; k < 64; k++)
        begin
            @(posedge mclk_in);
            s = (which == 0) ? irq_h : (which == 1) ? irq_l : wake;
            if (s === 1'b1)
                break;
        end
        if (k == 64)
        begin
            n_errors++;
            $display("MISMATCH at %0t: request never came", $time);
            give_verdict();
        end
    endtask

    // Reset values, read-only bits, unmapped place
    task automatic t_regs();
        rchk(OFS_RX_STATUS_CTL, 8'h00);
        rchk(OFS_TX_STATUS_CTL, 8'h02);
        wr(OFS_RX_STATUS_CTL, 8'h07);
        rchk(OFS_RX_STATUS_CTL, 8'h00);
        wr(3'h7, 8'hFF);
        rchk(3'h7, 8'h00);
        wr(OFS_DIV_HIGH, 8'hA5);
        rchk(OFS_DIV_HIGH, 8'hA5);
        wr(OFS_TX_STATUS_CTL, 8'h04);
        wr(OFS_IRQ_CTL, 8'h07);
    endtask

    // Eight-bit frames at both sample rates
    task automatic t_rx8();
        wr(OFS_RX_STATUS_CTL, 8'h90);
        remote.send(9'h0A5, 8, 1'b1);
        wait_for(0);
        rchk(OFS_RX_STATUS_CTL, 8'h90);
        rchk(OFS_RX_BUFFER, 8'hA5);
        rchk(OFS_IRQ_CTL, 8'h07);
        wr(OFS_TX_STATUS_CTL, 8'h00);
        remote.bit_clks = 64;
        remote.send(9'h03C, 8, 1'b1);
        wait_for(0);
        rchk(OFS_RX_BUFFER, 8'h3C);
        remote.bit_clks = 16;
        wr(OFS_TX_STATUS_CTL, 8'h04);
        // Wide divisor, one tick every second clock
        wr(OFS_DIV_HIGH, 8'h00);
        wr(OFS_BAUD_CTL, 8'h08);
        wr(OFS_DIV_LOW, 8'h01);
        remote.bit_clks = 32;
        remote.send(9'h0C5, 8, 1'b1);
        wait_for(0);
        rchk(OFS_RX_BUFFER, 8'hC5);
        wr(OFS_BAUD_CTL, 8'h00);
        wr(OFS_DIV_LOW, 8'h00);
        remote.bit_clks = 16;
    endtask

    // Nine-bit frames with and without address detect
    task automatic t_rx9();
        wr(OFS_RX_STATUS_CTL, 8'hD8);
        remote.send(9'h055, 9, 1'b1);
        rchk(OFS_IRQ_CTL, 8'h07);
        remote.send(9'h1C3, 9, 1'b1);
        wait_for(0);
        rchk(OFS_RX_STATUS_CTL, 8'hD9);
        rchk(OFS_RX_BUFFER, 8'hC3);
        wr(OFS_RX_STATUS_CTL, 8'hD0);
        remote.send(9'h066, 9, 1'b1);
        wait_for(0);
        rchk(OFS_RX_BUFFER, 8'h66);
    endtask

    // Low priority, then masked request
    task automatic t_prio();
        wr(OFS_RX_STATUS_CTL, 8'h90);
        wr(OFS_IRQ_CTL, 8'h0D);
        remote.send(9'h05A, 8, 1'b1);
        wait_for(1);
        rchk(OFS_RX_BUFFER, 8'h5A);
        wr(OFS_IRQ_CTL, 8'h0C);
        remote.send(9'h03C, 8, 1'b1);
        rchk(OFS_IRQ_CTL, 8'h1C);
        chk({6'h00, irq_h, irq_l}, 8'h00);
        rchk(OFS_RX_BUFFER, 8'h3C);
        wr(OFS_IRQ_CTL, 8'h07);
    endtask

    // Framing and overrun errors, cleared by receive off
    task automatic t_err();
        remote.send(9'h0F0, 8, 1'b0);
        wait_for(0);
        rchk(OFS_RX_STATUS_CTL, 8'h94);
        rchk(OFS_RX_BUFFER, 8'hF0);
        wr(OFS_RX_STATUS_CTL, 8'h80);
        rchk(OFS_RX_STATUS_CTL, 8'h80);
        wr(OFS_RX_STATUS_CTL, 8'h90);
        remote.send(9'h011, 8, 1'b1);
        remote.send(9'h022, 8, 1'b1);
        rchk(OFS_RX_STATUS_CTL, 8'h92);
        rchk(OFS_RX_BUFFER, 8'h11);
        wr(OFS_RX_STATUS_CTL, 8'h80);
        rchk(OFS_RX_STATUS_CTL, 8'h80);
    endtask

    // No reception: receive off, clocked mode, sleep
    task automatic t_gate();
        remote.send(9'h077, 8, 1'b1);
        rchk(OFS_IRQ_CTL, 8'h07);
        wr(OFS_RX_STATUS_CTL, 8'h90);
        wr(OFS_TX_STATUS_CTL, 8'h14);
        remote.send(9'h077, 8, 1'b1);
        rchk(OFS_IRQ_CTL, 8'h07);
        wr(OFS_TX_STATUS_CTL, 8'h04);
        sleep <= 1'b1;
        remote.send(9'h077, 8, 1'b1);
        sleep <= 1'b0;
        rchk(OFS_IRQ_CTL, 8'h07);
    endtask

    // Wake on break awake, then asleep, then a normal frame
    task automatic t_wake();
        wr(OFS_BAUD_CTL, 8'h02);
        remote.wake_break();
        rchk(OFS_RX_STATUS_CTL, 8'h90);
        rchk(OFS_IRQ_CTL, 8'h17);
        rd(OFS_RX_BUFFER, v);
        wr(OFS_BAUD_CTL, 8'h02);
        rchk(OFS_BAUD_CTL, 8'h42);
        sleep <= 1'b1;
        remote.wake_break();
        chk({7'h00, wake}, 8'h01);
        rchk(OFS_BAUD_CTL, 8'h40);
        sleep <= 1'b0;
        rd(OFS_RX_BUFFER, v);
        rchk(OFS_IRQ_CTL, 8'h07);
        remote.send(9'h096, 8, 1'b1);
        wait_for(0);
        rchk(OFS_RX_BUFFER, 8'h96);
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_rx8();
        t_rx9();
        t_prio();
        t_err();
        t_gate();
        t_wake();
        give_verdict();
    end
endmodule

`default_nettype wire
